// File: shared/urd_pkg.sv
// urd_pkg: register map, field positions and shared types of the uart register block.
// assumes a 32-bit apb slave with byte addresses; every register holds one aligned word.
package urd_pkg;
  // byte offsets
  localparam logic [7:0] A_BUF  = 8'h00; // receive_buffer / transmit_holding / low latch
  localparam logic [7:0] A_IER  = 8'h04; // interrupt_enable_reg / high latch
  localparam logic [7:0] A_FCTL = 8'h08; // fifo mode control
  localparam logic [7:0] A_LCR  = 8'h0C; // line_control_reg
  localparam logic [7:0] A_LSR  = 8'h14; // line_status
  localparam logic [7:0] A_SCR  = 8'h1C; // scratch_pad
  localparam logic [7:0] A_DLL  = 8'h20; // baud_divisor_low, dedicated
  localparam logic [7:0] A_DLH  = 8'h24; // baud_divisor_high, dedicated
  localparam logic [7:0] A_PWR  = 8'h30; // power_emulation_control
  localparam logic [7:0] A_IST  = 8'h38; // sticky event status
  localparam logic [7:0] A_IMSK = 8'h3C; // event mask
  // field positions
  localparam int LCR_DIVISOR_ACCESS_SELECT  = 7;
  localparam int IER_RX_DATA_IRQ_ENABLE  = 0;
  localparam int FCTL_FEN  = 0;
  localparam int LSR_DR    = 0;
  localparam int PWR_TXEN  = 14;
  localparam int PWR_RXEN  = 13;
  localparam int PWR_FREE  = 0;
  localparam int IST_RXCH  = 0;
  localparam int IST_OVR   = 1;
  localparam int IST_TXLD  = 2;
  localparam int IST_W     = 3;
  // reset values and timing
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [1:0]  DIV_WAIT = 2'h2; // wait states on a divisor write
  // register target after address decode
  typedef enum logic [3:0] {
    T_RBR, T_DLL, T_IER, T_DLH, T_FCTL, T_LCR, T_LSR,
    T_SCR, T_PWR, T_IST, T_IMSK, T_NONE
  } urd_tgt_t;
  // power_emulation_control fields that hold state
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic free;
  } urd_pwr_t;
endpackage

// File: hw/urd_uart_regs.sv
// urd_uart_regs: apb register side of a uart; receive flag, rx fifo, divisor latches,
// scratch, power/emulation control and a masked event interrupt.
// assumes shift logic outside delivers whole characters and reports transmitter busy.
// integration notes
// - bus: zero wait states for every access except divisor writes,
//   which hold pready low for two extra access cycles while the
//   baud generator takes the new value
// - read data is caught in the setup cycle, so a character that
//   lands in that same cycle is seen only by the next read
// - a read of the buffer pops a character only when data was
//   already present at its setup cycle, so an empty read is harmless
// - unmapped addresses answer with pslverr and read as zero
// - receive buffer: one slot in non-fifo mode, RX_DEPTH slots in
//   fifo mode; a full fifo drops the new character and flags overrun
// - changing the fifo mode or clearing the receiver enable empties
//   the buffer; its contents are not reset, only the pointers and count
// - events: char stored, overrun and transmit load set sticky bits;
//   software clears them by writing ones, and a new event in the
//   same cycle as the clear keeps its bit
// - status and mask share one layout: bit 0 char stored, bit 1
//   overrun, bit 2 transmit load
// - irq is registered, so it follows its cause by one cycle
// - control register: transmit enable, receive enable and free run
//   are the only stored bits; every other bit reads as zero
// - a buffer write while the transmitter is disabled or halted is
//   dropped without a load strobe or an event
// - emulation halt waits for tx_busy to drop; the shift logic must
//   hold tx_busy high for the whole word it is sending
// - ce low freezes everything, bus answer included, so the host
//   must not start a transfer while the block is frozen
// - the divisor needs both latches written before the baud rate
//   is meaningful; reset leaves it at zero
`timescale 1ns/10ps
module urd_uart_regs
  import urd_pkg::*;
#(
  parameter int RX_DEPTH = 16,
  parameter int AW       = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          rx_char_valid,
  input  wire logic [7:0]    rx_char,
  input  wire logic          tx_busy,
  input  wire logic          emu_halt,
  output logic               tx_load,
  output logic      [7:0]    tx_data,
  output logic      [15:0]   baud_divisor,
  output logic               tx_enable,
  output logic               rx_enable,
  output logic               halted,
  output logic               irq
);
  localparam int PW = $clog2(RX_DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(RX_DEPTH);

  // depth must be a power of two so the pointers wrap by themselves
  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_chk
    $error("RX_DEPTH must be a power of two of at least 2");
  end

  // the register map reaches 0x3C, so a narrower address would alias
  if (AW < 6) begin : g_aw_chk
    $error("AW must be at least 6");
  end

  // register state; all cleared by presetn except the receive storage
  logic [7:0]      ier_ff, lcr_ff, scr_ff, dll_ff, dlh_ff, tx_data_ff;
  logic            fen_ff, tx_load_ff, halted_ff, irq_ff;
  logic            pready_ff, pslverr_ff, pop_ok_ff;
  logic [1:0]      wait_ff;
  logic [31:0]     prdata_ff;
  urd_pwr_t        pwr_ff;
  logic [IST_W-1:0] ist_ff, imsk_ff;
  logic [7:0]      mem [RX_DEPTH];
  logic [PW-1:0]   wp_ff, rp_ff;
  logic [PW:0]     cnt_ff;

  // address decode; the access bit only steers the two shared words
  // the dedicated latch addresses ignore it, so software may leave
  // the access bit cleared for good
  function automatic urd_tgt_t dec(input logic [AW-1:0] a, input logic divisor_access_select);
    urd_tgt_t t;
    t = T_NONE;
    case (a)
      AW'(A_BUF):  t = divisor_access_select ? T_DLL : T_RBR;
      AW'(A_IER):  t = divisor_access_select ? T_DLH : T_IER;
      AW'(A_FCTL): t = T_FCTL;
      AW'(A_LCR):  t = T_LCR;
      AW'(A_LSR):  t = T_LSR;
      AW'(A_SCR):  t = T_SCR;
      AW'(A_DLL):  t = T_DLL;
      AW'(A_DLH):  t = T_DLH;
      AW'(A_PWR):  t = T_PWR;
      AW'(A_IST):  t = T_IST;
      AW'(A_IMSK): t = T_IMSK;
      default:     t = T_NONE;
    endcase
    return t;
  endfunction

  // combinational helpers
  urd_tgt_t tgt;
  logic setup, done, wr_done, dr, pop, rx_in, full, wr_en, overrun;
  logic flush, halt_req, tx_fire;
  logic [PW-1:0] waddr;
  logic [15:0]   rd_val;

  // bus phases and decoded target
  // done is the one edge at which a transfer takes effect; setup, one
  // cycle earlier (three for a divisor write), only catches the answer
  assign tgt     = dec(paddr, lcr_ff[LCR_DIVISOR_ACCESS_SELECT]);
  assign setup   = psel & ~penable;
  assign done    = psel & penable & pready_ff;
  assign wr_done = done & pwrite;

  // receive side: flag, pop on a read that saw data, push when allowed
  // in non-fifo mode the single slot sits at the read pointer, so a
  // new character simply overwrites the old one
  assign dr      = (cnt_ff != '0);
  assign pop     = done & ~pwrite & (tgt == T_RBR) & pop_ok_ff;
  assign rx_in   = rx_char_valid & pwr_ff.rx_en & ~halted_ff;
  assign full    = fen_ff & (cnt_ff == DEPTH_C);
  assign waddr   = fen_ff ? wp_ff : rp_ff;
  assign wr_en   = rx_in & ~full;
  assign overrun = rx_in & (fen_ff ? full : (dr & ~pop));
  // a mode change or a disabled receiver empties the buffer
  // keeping stale characters across a mode change would mix orders
  assign flush   = ~pwr_ff.rx_en | (wr_done & (tgt == T_FCTL) & (pwdata[FCTL_FEN] != fen_ff));
  assign halt_req = emu_halt & ~pwr_ff.free;
  // transmit happens only when enabled and not halted
  // a dropped write leaves tx_data as it was
  assign tx_fire = wr_done & (tgt == T_RBR) & pwr_ff.tx_en & ~halted_ff;

  // read mux; reserved bits stay zero
  // only 16 bits are built here; the bus word pads the upper half
  // with zeros
  always_comb begin
    rd_val = HALF_RST;
    case (tgt)
      T_RBR:  rd_val[7:0] = mem[rp_ff];
      T_DLL:  rd_val[7:0] = dll_ff;
      T_DLH:  rd_val[7:0] = dlh_ff;
      T_IER:  rd_val[7:0] = ier_ff;
      T_FCTL: rd_val[FCTL_FEN] = fen_ff;
      T_LCR:  rd_val[7:0] = lcr_ff;
      T_LSR:  rd_val[LSR_DR] = dr;
      T_SCR:  rd_val[7:0] = scr_ff;
      T_PWR: begin
        rd_val[PWR_TXEN] = pwr_ff.tx_en;
        rd_val[PWR_RXEN] = pwr_ff.rx_en;
        rd_val[PWR_FREE] = pwr_ff.free;
      end
      T_IST:  rd_val[IST_W-1:0] = ist_ff;
      T_IMSK: rd_val[IST_W-1:0] = imsk_ff;
      default: rd_val = HALF_RST;
    endcase
  end

  // the answer is registered so pready and prdata come from flops,
  // with no wait state added, since the answer is caught in setup
  // apb answer: data is caught in setup, so access ends after one cycle
  // unless a divisor write needs the baud generator to settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= WORD_RST;
      wait_ff    <= 2'h0;
      pop_ok_ff  <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        prdata_ff  <= {16'h0000, rd_val};
        pslverr_ff <= (tgt == T_NONE);
        pop_ok_ff  <= dr;
        if (pwrite && (tgt == T_DLL || tgt == T_DLH)) begin
          wait_ff   <= DIV_WAIT;
          pready_ff <= 1'b0;
        end else begin
          pready_ff <= 1'b1;
        end
      end else if (done) begin
        pready_ff <= 1'b0;
      end else if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
        if (wait_ff == 2'h1) begin
          pready_ff <= 1'b1;
        end
      end
    end
  end

  // host-written configuration, taken at the completing edge
  // a write to an unmapped or read-only word falls to the default
  // branch and changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ier_ff  <= BYTE_RST;
      lcr_ff  <= BYTE_RST;
      scr_ff  <= BYTE_RST;
      fen_ff  <= 1'b0;
      pwr_ff  <= '0;
      imsk_ff <= '0;
    end else if (ce && wr_done) begin
      case (tgt)
        T_IER:  ier_ff <= pwdata[7:0];
        T_LCR:  lcr_ff <= pwdata[7:0];
        T_SCR:  scr_ff <= pwdata[7:0];
        T_FCTL: fen_ff <= pwdata[FCTL_FEN];
        T_PWR: begin
          pwr_ff.tx_en <= pwdata[PWR_TXEN];
          pwr_ff.rx_en <= pwdata[PWR_RXEN];
          pwr_ff.free  <= pwdata[PWR_FREE];
        end
        T_IMSK: imsk_ff <= pwdata[IST_W-1:0];
        default: ;
      endcase
    end
  end

  // divisor latches; the generator sees both bytes at once
  // writing one byte alone gives a mixed divisor until the other
  // byte follows, so software should write both back to back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_ff <= BYTE_RST;
      dlh_ff <= BYTE_RST;
    end else if (ce && wr_done) begin
      if (tgt == T_DLL) begin
        dll_ff <= pwdata[7:0];
      end
      if (tgt == T_DLH) begin
        dlh_ff <= pwdata[7:0];
      end
    end
  end

  // receive storage; no reset so it maps to plain memory
  // reads of a slot never written return unknown data, which the
  // flag keeps software from trusting
  always_ff @(posedge pclk) begin
    if (ce && wr_en) begin
      mem[waddr] <= rx_char;
    end
  end

  // pointers wrap on their own because the depth is a power of two;
  // the count carries one extra bit to tell full from empty
  // pointers and count; in non-fifo mode one slot is overwritten in place
  // and a new character beats a read that completes in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_ff  <= '0;
        rp_ff  <= '0;
        cnt_ff <= '0;
      end else if (!fen_ff) begin
        if (wr_en) begin
          cnt_ff <= (PW+1)'(1);
        end else if (pop) begin
          cnt_ff <= '0;
        end
      end else begin
        if (wr_en) begin
          wp_ff <= wp_ff + 1'b1;
        end
        if (pop) begin
          rp_ff <= rp_ff + 1'b1;
        end
        cnt_ff <= cnt_ff + (PW+1)'(wr_en) - (PW+1)'(pop);
      end
    end
  end

  // transmit hand-off: one-cycle load strobe with the byte
  // the shift logic must take the byte on the strobe; there is no
  // holding buffer behind it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_load_ff <= 1'b0;
      tx_data_ff <= BYTE_RST;
    end else if (ce) begin
      tx_load_ff <= tx_fire;
      if (tx_fire) begin
        tx_data_ff <= pwdata[7:0];
      end
    end
  end

  // emulation halt waits for an idle transmitter so no word is cut short
  // with free run set the request is ignored and the port keeps going;
  // dropping the request releases the halt one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_ff <= 1'b0;
    end else if (ce) begin
      halted_ff <= halt_req & (halted_ff | ~tx_busy);
    end
  end

  // sticky events: a new event wins over a clear in the same cycle
  // losing an event to a racing clear would hide it from software
  // for good, while a spare interrupt costs only one more read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff <= '0;
    end else if (ce) begin
      ist_ff <= (ist_ff & ~((wr_done && tgt == T_IST) ? pwdata[IST_W-1:0] : '0))
              | {tx_fire, overrun, wr_en};
    end
  end

  // interrupt level; silent while halted
  // causes still pending when the halt ends raise irq again one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= ~halted_ff & ((dr & ier_ff[IER_RX_DATA_IRQ_ENABLE]) | (|(ist_ff & imsk_ff)));
    end
  end

  // every output comes straight from a flop, so nothing downstream
  // sees a glitch from the decode
  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign tx_load      = tx_load_ff;
  assign tx_data      = tx_data_ff;
  assign baud_divisor = {dlh_ff, dll_ff};
  assign tx_enable    = pwr_ff.tx_en;
  assign rx_enable    = pwr_ff.rx_en;
  assign halted       = halted_ff;
  assign irq          = irq_ff;
endmodule

// File: test/urd_uart_regs_properties.sv
// urd_uart_regs_properties: port-level checks of the uart register block.
// assumes ce held high; sees only the top ports and is bound below.
`timescale 1ns/10ps
module urd_uart_regs_chk
  import urd_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          tx_busy,
  input wire logic          emu_halt,
  input wire logic          tx_load,
  input wire logic          tx_enable,
  input wire logic [15:0]   baud_divisor,
  input wire logic          halted,
  input wire logic          irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup cycle of any transfer
  wire su = psel && !penable;
  property p_div_wait;
    su && pwrite && (paddr == A_DLL || paddr == A_DLH) |=> !pready [*2] ##1 pready;
  endproperty
  a_div_wait: assert property (p_div_wait) else $error("divisor wait");
  property p_one;
    pready |=> !pready;
  endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_scr;
    su && !pwrite && paddr == A_SCR |=> pready && prdata[31:8] == 24'h000000;
  endproperty
  a_scr: assert property (p_scr) else $error("scratch upper bits");
  property p_pwr;
    su && !pwrite && paddr == A_PWR |=> pready && prdata[12:1] == 12'h000;
  endproperty
  a_pwr: assert property (p_pwr) else $error("control reserved bits");
  // the divisor only moves after a completed write
  property p_baud;
    $changed(baud_divisor) |-> $past(psel && penable && pready && pwrite);
  endproperty
  a_baud: assert property (p_baud) else $error("divisor moved");
  property p_txl;
    tx_load |-> $past(tx_enable);
  endproperty
  a_txl: assert property (p_txl) else $error("load while disabled");
  property p_hrise;
    $rose(halted) |-> $past(emu_halt && !tx_busy);
  endproperty
  a_hrise: assert property (p_hrise) else $error("halt mid word");
  property p_hirq;
    halted && $past(halted) |-> !irq;
  endproperty
  a_hirq: assert property (p_hirq) else $error("irq while halted");
  c_div: cover property (su && pwrite && paddr == A_DLH);
  c_halt: cover property ($rose(halted));
  c_irq: cover property ($rose(irq));
endmodule
bind urd_uart_regs urd_uart_regs_chk #(.AW(AW)) i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .tx_busy,
  .emu_halt, .tx_load, .tx_enable, .baud_divisor, .halted, .irq
);

// File: test/urd_far_end.sv
// urd_far_end: remote serial end, seen as whole characters and a busy level.
// assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/10ps
module urd_far_end (
  input wire logic  pclk,
  output logic      rx_char_valid,
  output logic [7:0] rx_char,
  output logic      tx_busy
);
  // idle line at start
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    tx_busy = 1'b0;
  end
  // one character pulse; data scrambled after so stale bytes never look valid
  task automatic send(input logic [7:0] c);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
  endtask
  task automatic busy(input logic b);
    @(posedge pclk);
    tx_busy <= b;
  endtask
endmodule

// File: test/urd_uart_regs_tb.sv
// urd_uart_regs_tb: directed scenarios for the uart register block.
// assumes the far-end model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module urd_uart_regs_tb
  import urd_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic emu_halt = 1'b0, pready, pslverr, perr, tx_load, tx_enable, rx_enable, halted, irq;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00, rx_char, tx_data;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] baud_divisor;
  logic rx_char_valid, tx_busy;
  int err_total = 0, checks_done = 0, ws;
  always #2.5 pclk = ~pclk;
  urd_uart_regs i_dut (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_char_valid, .rx_char, .tx_busy, .emu_halt, .tx_load,
    .tx_data, .baud_divisor, .tx_enable, .rx_enable, .halted, .irq
  );
  urd_far_end i_far (.pclk, .rx_char_valid, .rx_char, .tx_busy);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one apb transfer; the wait is bounded so a stuck slave ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 30);
    if (n >= 30) begin
      err_total++;
      finish_test();
    end
    rd = prdata;
    perr = pslverr;
    ws = n - 1;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic s_regs();
    rdc(A_PWR, 32'h0);
    wr(A_PWR, 32'hFFFF_FFFF);
    rdc(A_PWR, 32'h6001);
    wr(A_SCR, 32'hFFFF_FFA5);
    rdc(A_SCR, 32'hA5);
    rdc(8'h10, 32'h0);
    chk(perr, 1'b1);
  endtask
  task automatic s_div();
    wr(A_DLL, 32'h34);
    chk(ws, 2);
    wr(A_DLH, 32'h12);
    chk(baud_divisor, 16'h1234);
    wr(A_LCR, 32'h80);
    wr(A_BUF, 32'h78);
    chk(ws, 2);
    wr(A_IER, 32'h9A);
    chk(baud_divisor, 16'h9A78);
    rdc(A_BUF, 32'h78);
    chk(ws, 0);
    wr(A_LCR, 32'h0);
    rdc(A_DLH, 32'h9A);
  endtask
  task automatic s_rx();
    wr(A_PWR, 32'h6000);
    wr(A_IER, 32'h1);
    i_far.send(8'h5A);
    rdc(A_LSR, 32'h1);
    chk(irq, 1'b1);
    rdc(A_BUF, 32'h5A);
    rdc(A_LSR, 32'h0);
    chk(irq, 1'b0);
  endtask
  task automatic s_fifo();
    wr(A_FCTL, 32'h1);
    i_far.send(8'h11);
    i_far.send(8'h22);
    rdc(A_LSR, 32'h1);
    rdc(A_BUF, 32'h11);
    rdc(A_LSR, 32'h1);
    rdc(A_BUF, 32'h22);
    rdc(A_LSR, 32'h0);
    wr(A_FCTL, 32'h0);
  endtask
  // event status raised, masked and cleared
  task automatic s_int();
    wr(A_IER, 32'h0);
    wr(A_IMSK, 32'h1);
    i_far.send(8'h33);
    rdc(A_IST, 32'h1);
    chk(irq, 1'b1);
    wr(A_IMSK, 32'h0);
    rdc(A_IST, 32'h1);
    chk(irq, 1'b0);
    wr(A_IST, 32'h1);
    rdc(A_IST, 32'h0);
    rdc(A_BUF, 32'h33);
  endtask
  task automatic s_tx();
    wr(A_BUF, 32'hC3);
    chk(tx_load, 1'b1);
    chk(tx_data, 8'hC3);
    wr(A_PWR, 32'h2000);
    wr(A_BUF, 32'h3C);
    chk(tx_load, 1'b0);
    chk(tx_enable, 1'b0);
  endtask
  task automatic s_halt();
    wr(A_PWR, 32'h6000);
    i_far.busy(1'b1);
    emu_halt <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(halted, 1'b0);
    i_far.busy(1'b0);
    repeat (3) @(posedge pclk);
    chk(halted, 1'b1);
    i_far.send(8'h44);
    rdc(A_LSR, 32'h0);
    wr(A_SCR, 32'h7E);
    rdc(A_SCR, 32'h7E);
    emu_halt <= 1'b0;
    wr(A_PWR, 32'h6001);
    emu_halt <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(halted, 1'b0);
    emu_halt <= 1'b0;
  endtask
  // a character offered while frozen must not be taken
  task automatic s_ce();
    ce <= 1'b0;
    i_far.send(8'h55);
    ce <= 1'b1;
    rdc(A_LSR, 32'h0);
  endtask
  // reset in mid-run clears the latches and control
  task automatic s_rst();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(baud_divisor, 16'h0000);
    chk(tx_enable, 1'b0);
    presetn <= 1'b1;
    rdc(A_SCR, 32'h0);
  endtask
  // reset held for twenty cycles, then the scenarios in turn
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_div();
    s_rx();
    s_fifo();
    s_int();
    s_tx();
    s_halt();
    s_ce();
    s_rst();
    finish_test();
  end
endmodule
